// [sgm_carrier_if.sv]
/*
 Carrier path carrier: select, polarity and enable in, carrier out.
 Assumes one owner (the top) and one chooser per instance.
*/
`timescale 1ns/1ps
`default_nettype none
interface sgm_carrier_if;
   import sgm_pkg::*;
   sgm_code_t sel; // Stored select code
   logic invert; // Polarity swap
   logic active; // Modulator enabled
   logic carrier; // Resulting carrier
   // Top side drives configuration
   modport owner (output sel, output invert, output active,
      input carrier);
   // Chooser side returns the carrier
   modport chooser (input sel, input invert, input active,
      output carrier);
endinterface
`default_nettype wire

// [sgm_carrier_sel.sv]
/*
 One carrier chooser: picks a source by code, forces ground while
 the modulator is off, and applies the polarity swap only while it is on.
 Assumes sources arrive already on the clock's domain.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sgm_defs.svh"
module sgm_carrier_sel #(
   parameter bit HAS_PIN_TWO = 1'b1
) (
   // Configuration and result
   sgm_carrier_if.chooser cif,
   // Candidate sources
   input wire logic pin_one,
   input wire logic pin_two,
   input wire logic refclk,
   input wire logic pwm
);
   import sgm_pkg::*;
   logic raw; // Source before polarity
   // Source choice; off means ground with no swap, so no output
   always_comb
   begin
      raw = 1'b0;
      if (cif.active)
      begin
         case (cif.sel)
            `SGM_CAR_PIN1: raw = pin_one; // RQ4
            `SGM_CAR_PIN2: raw = HAS_PIN_TWO ? pin_two : 1'b0; // RQ4
            `SGM_CAR_REFCLK: raw = refclk; // RQ4
            `SGM_CAR_PWM: raw = pwm; // RQ4
            default: raw = 1'b0;
         endcase
      end
      cif.carrier = raw ^ (cif.invert & cif.active); // RQ8 RQ16
   end
endmodule // sgm_carrier_sel
`default_nettype wire

// [sgm_defs.svh]
/*
 Constants of the signal modulator: register offsets, bit places,
 reset values, write masks and source select codes.
 Assumes it is included by bare name wherever these are needed.
*/
`ifndef SGM_DEFS_SVH
`define SGM_DEFS_SVH
// Register offsets on the 2-bit register port
`define SGM_OFS_CONTROL 2'h0
`define SGM_OFS_SOURCE 2'h1
`define SGM_OFS_CARRIER_HIGH_SIGNAL 2'h2
`define SGM_OFS_CARRIER_LOW_SIGNAL 2'h3
// Control register bit places
`define SGM_CTL_EN 7
`define SGM_CTL_OE 6
`define SGM_CTL_SLEW 5
`define SGM_CTL_OINV 4
`define SGM_CTL_MON 3
`define SGM_CTL_SWBIT 0
// Shared bit 7 (pin block) and carrier bits
`define SGM_PIN_DIS 7
`define SGM_CAR_INV 6
`define SGM_CAR_SYNC 5
// Reset values and writable masks
`define SGM_CTL_RESET 8'h20
`define SGM_CFG_RESET 8'h00
`define SGM_CTL_WMASK 8'hF1
`define SGM_SRC_WMASK 8'h8F
`define SGM_CAR_WMASK 8'hEF
// Modulator source codes
`define SGM_MOD_SW 4'h0
`define SGM_MOD_PIN 4'h1
`define SGM_MOD_PWM 4'h2
`define SGM_MOD_CMP 4'h6
`define SGM_MOD_SPI 4'h8
`define SGM_MOD_UART 4'hA
// Carrier source codes
`define SGM_CAR_GND 4'h0
`define SGM_CAR_PIN1 4'h1
`define SGM_CAR_PIN2 4'h2
`define SGM_CAR_REFCLK 4'h3
`define SGM_CAR_PWM 4'h4
`endif

// [sgm_far_model.sv]
/*
 Far-side model: the peripheral outputs and input pins that feed
 the modulator. Assumes the bench sets levels just after an edge.
*/
`timescale 1ns/1ps
`default_nettype none
module sgm_far_model (
   // Clock
   input wire logic clock,
   // Levels asked for by the bench
   input wire logic [7:0] level,
   // Peripheral outputs on clock
   output logic pwm_out,
   output logic comparator_out,
   output logic spi_data_out,
   output logic uart_tx_out,
   output logic reference_clock_output,
   // Asynchronous pins
   output logic modulation_input_pin,
   output logic carrier_input_pin_one,
   output logic carrier_input_pin_two
);
   logic [4:0] per_q = 5'h00; // On-chip peripherals, registered
   // Peripherals move only on the clock, like on-chip logic
   always @(posedge clock)
   begin
      per_q <= level[4:0];
   end
   assign {reference_clock_output, uart_tx_out, spi_data_out,
      comparator_out, pwm_out} = per_q;
   // Pins move off the edge so the synchroniser sees a real skew
   assign #3 {carrier_input_pin_two, carrier_input_pin_one,
      modulation_input_pin} = level[7:5];
endmodule // sgm_far_model
`default_nettype wire

// [sgm_pkg.sv]
/*
 Types of the signal modulator.
 Assumes sgm_defs.svh holds every numeric constant.
*/
package sgm_pkg;
   // Register port address
   typedef logic [1:0] sgm_addr_t;
   // Byte-wide register
   typedef logic [7:0] sgm_byte_t;
   // Four-bit source select code
   typedef logic [3:0] sgm_code_t;
   // Carrier being mixed at present
   typedef enum logic
   {
      SGM_LOW = 1'b0,
      SGM_HIGH = 1'b1
   } sgm_state_t;
endpackage

// [sgm_sync3.sv]
/*
 Three-stage synchroniser for pin inputs, one per bit.
 Assumes inputs are asynchronous to clock; output moves once
 the second and third stages agree.
*/
`timescale 1ns/1ps
`default_nettype none
module sgm_sync3 #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Pins in, settled values out
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] stable_out
);
   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         logic s1_reg, s2_reg, s3_reg; // First read only by second
         // Shift chain plus agreement filter
         always_ff @(posedge clock)
         begin
            if (!rst_n)
            begin
               s1_reg <= 1'b0;
               s2_reg <= 1'b0;
               s3_reg <= 1'b0;
               stable_out[i] <= 1'b0;
            end
            else
            begin
               s1_reg <= async_in[i];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
               if (s2_reg == s3_reg)
                  stable_out[i] <= s3_reg;
            end
         end
      end
   endgenerate
endmodule // sgm_sync3
`default_nettype wire

// [sgm_top.sv]
/*
 Signal modulator top: four byte registers, source selection,
 carrier synchronisation, mixing and the output pin drive.
 Assumes peripheral signals are on clock; pins are not and are
 synchronised here.
*/
// The register addresses and the plain strobed port were left to the implementer.
// Behaviour
// [RQ1] Modulator source from four-bit code
// [RQ2] High carrier chosen by its own field
// [RQ3] Low carrier chosen by its own field
// [RQ4] Carrier codes map; pin two high only
// [RQ5] Modulator high uses high carrier, else low
// [RQ6] Synced switch waits for carrier to fall
// [RQ7] Separate sync bits, each for leaving
// [RQ8] Invert bits swap carriers before mixing
// [RQ9] Carrier pin-disable blocks peripheral pin
// [RQ10] Source pin-disable blocks peripheral pin
// [RQ11] Software bit picks high or low carrier
// [RQ12] Software selects software bit first
// [RQ13] Output invert bit flips the output
// [RQ14] Slew bit drives slew-limit control
// [RQ15] Enable mixes; clear gives no output
// [RQ16] Disabled forces ground and software bit
// [RQ17] Pin enable gates output onto pin
// [RQ18] Pin held low while pin disabled
// [RQ19] Read-only monitor bit shows output
// [RQ20] Keeps working in sleep unchanged
// [RQ21] Any reset leaves modulator disabled
// [RQ22] Control resets clear except slew set
// [RQ23] Firmware configures before enabling
// [RQ24] Unimplemented bits read zero
// [RQ25] Pending switch released on outgoing fall
`timescale 1ns/1ps
`default_nettype none
`include "sgm_defs.svh"
module sgm_top (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Register port
   input wire sgm_pkg::sgm_addr_t reg_addr,
   input wire sgm_pkg::sgm_byte_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output sgm_pkg::sgm_byte_t reg_rdata,
   // Peripheral signals on clock
   input wire logic pwm_out,
   input wire logic comparator_out,
   input wire logic spi_data_out,
   input wire logic uart_tx_out,
   input wire logic reference_clock_output,
   // Asynchronous pins
   input wire logic modulation_input_pin,
   input wire logic carrier_input_pin_one,
   input wire logic carrier_input_pin_two,
   // Output pin controls
   output logic modulated_out_pin,
   output logic output_slew_limit,
   // Peripheral pin blocks
   output logic pwm_pin_block,
   output logic comparator_pin_block,
   output logic spi_pin_block,
   output logic uart_pin_block,
   output logic refclk_pin_block
);
   import sgm_pkg::*;

   // Registers
   sgm_byte_t ctl_reg; // Control
   sgm_byte_t src_reg; // Modulator source
   sgm_byte_t carrier_high_signal_reg; // High carrier
   sgm_byte_t carrier_low_signal_reg; // Low carrier
   sgm_byte_t rdata_next; // Read mux
   // Synchronised pins
   logic [2:0] pins_sync;
   // Mixing path
   logic mod_sig; // Chosen modulator signal
   logic en; // Modulator enable
   logic hi_car, lo_car; // Carriers after polarity
   logic hi_prev_reg, lo_prev_reg; // Carriers one cycle back
   logic hi_fall, lo_fall; // Falling edges
   sgm_state_t cur_state, state_next; // Carrier in use
   logic mix; // Mixed signal
   logic mod_value_reg, mod_value_next; // Modulator output
   // Pin blocks, next values
   logic [4:0] block_next;

   // Carrier path carriers
   sgm_carrier_if hi_if ();
   sgm_carrier_if lo_if ();

   // Decode "this code picks that source, with its block bit"
   function automatic logic picks(input sgm_byte_t r,
      input sgm_code_t code);
      picks = r[`SGM_PIN_DIS] && (r[3:0] == code);
   endfunction

   assign en = ctl_reg[`SGM_CTL_EN];

   // Pins cross into clock through four flops: three stages and the agreement register
   sgm_sync3 #(
      .W(3)
   ) u_sync (
      .clock(clock),
      .rst_n(rst_n),
      .async_in({carrier_input_pin_two, carrier_input_pin_one,
         modulation_input_pin}),
      .stable_out(pins_sync)
   );

   // High carrier takes its code from its own register
   assign hi_if.sel = carrier_high_signal_reg[3:0]; // RQ2
   assign hi_if.invert = carrier_high_signal_reg[`SGM_CAR_INV]; // RQ8
   assign hi_if.active = en; // RQ16
   assign hi_car = hi_if.carrier;
   // Low carrier is independent of the high one
   assign lo_if.sel = carrier_low_signal_reg[3:0]; // RQ3
   assign lo_if.invert = carrier_low_signal_reg[`SGM_CAR_INV]; // RQ8
   assign lo_if.active = en; // RQ16
   assign lo_car = lo_if.carrier;

   // High chooser may reach pin two
   sgm_carrier_sel #(
      .HAS_PIN_TWO(1'b1)
   ) u_hi_sel (
      .cif(hi_if.chooser),
      .pin_one(pins_sync[1]),
      .pin_two(pins_sync[2]),
      .refclk(reference_clock_output),
      .pwm(pwm_out)
   );

   // Low chooser: code for pin two is reserved here
   sgm_carrier_sel #(
      .HAS_PIN_TWO(1'b0)
   ) u_lo_sel (
      .cif(lo_if.chooser),
      .pin_one(pins_sync[1]),
      .pin_two(pins_sync[2]),
      .refclk(reference_clock_output),
      .pwm(pwm_out)
   );

   // Register writes; no clock gating anywhere, so sleep is moot
   always_ff @(posedge clock) // RQ20
   begin
      if (!rst_n)
      begin
         ctl_reg <= `SGM_CTL_RESET; // RQ21 RQ22
         src_reg <= `SGM_CFG_RESET;
         carrier_high_signal_reg <= `SGM_CFG_RESET;
         carrier_low_signal_reg <= `SGM_CFG_RESET;
      end
      else if (reg_wr)
      begin
         // Unwritable bits stay zero through the masks
         if (reg_addr == `SGM_OFS_CONTROL)
            ctl_reg <= reg_wdata & `SGM_CTL_WMASK; // RQ24
         else if (reg_addr == `SGM_OFS_SOURCE)
            src_reg <= reg_wdata & `SGM_SRC_WMASK; // RQ24
         else if (reg_addr == `SGM_OFS_CARRIER_HIGH_SIGNAL)
            carrier_high_signal_reg <= reg_wdata & `SGM_CAR_WMASK;
         else if (reg_addr == `SGM_OFS_CARRIER_LOW_SIGNAL)
            carrier_low_signal_reg <= reg_wdata & `SGM_CAR_WMASK;
      end
   end

   // Read mux; monitor bit shows modulator output, not stored
   always_comb
   begin
      rdata_next = `SGM_CFG_RESET;
      if (reg_addr == `SGM_OFS_CONTROL)
      begin
         rdata_next = ctl_reg;
         rdata_next[`SGM_CTL_MON] = mod_value_reg; // RQ19
      end
      else if (reg_addr == `SGM_OFS_SOURCE)
         rdata_next = src_reg; // RQ24
      else if (reg_addr == `SGM_OFS_CARRIER_HIGH_SIGNAL)
         rdata_next = carrier_high_signal_reg;
      else if (reg_addr == `SGM_OFS_CARRIER_LOW_SIGNAL)
         rdata_next = carrier_low_signal_reg;
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         reg_rdata <= `SGM_CFG_RESET;
      else if (reg_rd)
         reg_rdata <= rdata_next;
      else
         reg_rdata <= `SGM_CFG_RESET;
   end

   // Modulator source; disabled means software bit only
   always_comb
   begin
      mod_sig = ctl_reg[`SGM_CTL_SWBIT]; // RQ11 RQ16
      if (en)
      begin
         case (src_reg[3:0]) // RQ1
            `SGM_MOD_SW: mod_sig = ctl_reg[`SGM_CTL_SWBIT];
            `SGM_MOD_PIN: mod_sig = pins_sync[0];
            `SGM_MOD_PWM: mod_sig = pwm_out;
            `SGM_MOD_CMP: mod_sig = comparator_out;
            `SGM_MOD_SPI: mod_sig = spi_data_out;
            `SGM_MOD_UART: mod_sig = uart_tx_out;
            default: mod_sig = 1'b0;
         endcase
      end
   end

   // Edge detect on carriers after their polarity swap
   assign hi_fall = hi_prev_reg && !hi_car; // RQ25
   assign lo_fall = lo_prev_reg && !lo_car; // RQ25

   // Remember carriers for the edge detect
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         hi_prev_reg <= 1'b0;
         lo_prev_reg <= 1'b0;
      end
      else
      begin
         hi_prev_reg <= hi_car;
         lo_prev_reg <= lo_car;
      end
   end

   // Carrier switch: a mismatch is the pending switch; it cancels
   // itself if the modulator returns before the carrier falls
   always_comb
   begin
      state_next = cur_state;
      case (cur_state)
         SGM_HIGH:
         begin
            // Leaving high waits on its own sync bit only
            if (!mod_sig && (!carrier_high_signal_reg[`SGM_CAR_SYNC] || hi_fall))
               state_next = SGM_LOW; // RQ6 RQ7 RQ25
         end
         SGM_LOW:
         begin
            if (mod_sig && (!carrier_low_signal_reg[`SGM_CAR_SYNC] || lo_fall))
               state_next = SGM_HIGH; // RQ6 RQ7 RQ25
         end
         default: state_next = SGM_LOW;
      endcase
   end

   // Carrier state register
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         cur_state <= SGM_LOW;
      else
         cur_state <= state_next;
   end

   // Mix: high carrier while the next carrier state is high, low otherwise
   assign mix = (state_next == SGM_HIGH) ? hi_car : lo_car; // RQ5
   // Off gives no output even with the output swap set
   assign mod_value_next = en && (mix ^ ctl_reg[`SGM_CTL_OINV]); // RQ13 RQ15

   // Output drive; pin low while its enable is clear
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         mod_value_reg <= 1'b0;
         modulated_out_pin <= 1'b0;
         output_slew_limit <= 1'b1;
      end
      else
      begin
         mod_value_reg <= mod_value_next;
         modulated_out_pin <= ctl_reg[`SGM_CTL_OE] &&
            mod_value_next; // RQ17 RQ18
         output_slew_limit <= ctl_reg[`SGM_CTL_SLEW]; // RQ14
      end
   end

   // Peripheral pin blocks, from modulator and carrier picks
   always_comb
   begin
      block_next[0] = picks(src_reg, `SGM_MOD_PWM) ||
         picks(carrier_high_signal_reg, `SGM_CAR_PWM) ||
         picks(carrier_low_signal_reg, `SGM_CAR_PWM); // RQ9 RQ10
      block_next[1] = picks(src_reg, `SGM_MOD_CMP); // RQ10
      block_next[2] = picks(src_reg, `SGM_MOD_SPI); // RQ10
      block_next[3] = picks(src_reg, `SGM_MOD_UART); // RQ10
      block_next[4] = picks(carrier_high_signal_reg, `SGM_CAR_REFCLK) ||
         picks(carrier_low_signal_reg, `SGM_CAR_REFCLK); // RQ9
   end

   // Register the blocks so every output is a flop
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         pwm_pin_block <= 1'b0;
         comparator_pin_block <= 1'b0;
         spi_pin_block <= 1'b0;
         uart_pin_block <= 1'b0;
         refclk_pin_block <= 1'b0;
      end
      else
      begin
         pwm_pin_block <= block_next[0];
         comparator_pin_block <= block_next[1];
         spi_pin_block <= block_next[2];
         uart_pin_block <= block_next[3];
         refclk_pin_block <= block_next[4];
      end
   end

   // Checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   // Waiting to leave high with sync on and no fall
   sequence s_hold_high;
      cur_state == SGM_HIGH && !mod_sig &&
         carrier_high_signal_reg[`SGM_CAR_SYNC] && !hi_fall;
   endsequence
   // Leaving low with no sync
   sequence s_free_low;
      cur_state == SGM_LOW && mod_sig && !carrier_low_signal_reg[`SGM_CAR_SYNC];
   endsequence
   // Control read request
   sequence s_ctl_read;
      reg_rd && reg_addr == `SGM_OFS_CONTROL;
   endsequence

   a_reset_ctl: assert property ( // RQ22
      @(posedge clock) disable iff (1'b0)
      !rst_n |=> ctl_reg == `SGM_CTL_RESET && !modulated_out_pin)
      else $error("control not at reset value");
   a_sync_hold: assert property ( // RQ6
      s_hold_high |=> cur_state == SGM_HIGH)
      else $error("left high carrier before it fell");
   a_free_switch: assert property ( // RQ7
      s_free_low |=> cur_state == SGM_HIGH)
      else $error("unsynced switch to high delayed");
   a_pin_low_off: assert property ( // RQ18
      !ctl_reg[`SGM_CTL_OE] |=> !modulated_out_pin)
      else $error("pin driven while pin enable clear");
   a_pin_follow: assert property ( // RQ17
      ctl_reg[`SGM_CTL_OE] |=> modulated_out_pin == mod_value_reg)
      else $error("pin does not follow modulator output");
   a_off_quiet: assert property ( // RQ15
      !en [*2] |=> !mod_value_reg)
      else $error("output while disabled");
   a_sw_source: assert property ( // RQ11
      en && src_reg[3:0] == `SGM_MOD_SW |->
      mod_sig == ctl_reg[`SGM_CTL_SWBIT])
      else $error("software bit not used as source");
   a_monitor_bit: assert property ( // RQ19
      s_ctl_read |=> reg_rdata[`SGM_CTL_MON] == $past(mod_value_reg))
      else $error("monitor bit wrong");
   a_slew_ctl: assert property ( // RQ14
      ##1 output_slew_limit == $past(ctl_reg[`SGM_CTL_SLEW]))
      else $error("slew control not following bit");
   a_zero_bits: assert property ( // RQ24
      reg_rd |=> ($past(reg_addr) != `SGM_OFS_CONTROL ||
      reg_rdata[2:1] == 2'h0) &&
      ($past(reg_addr) != `SGM_OFS_SOURCE || reg_rdata[6:4] == 3'h0))
      else $error("unimplemented bits not zero");
   a_pwm_block: assert property ( // RQ10
      picks(src_reg, `SGM_MOD_PWM) |=> pwm_pin_block)
      else $error("pwm pin not blocked");
endmodule // sgm_top
`default_nettype wire

// [sgm_top_test.sv]
/*
 Self-checking bench of the signal modulator top.
 Assumes sgm_far_model supplies every source signal.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sgm_defs.svh"
module sgm_top_test;
   import sgm_pkg::*;
   logic clock = 1'b0; // 100 MHz
   logic rst_n = 1'b0; // Held for 20 cycles
   sgm_addr_t reg_addr = 2'h0;
   sgm_byte_t reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   sgm_byte_t reg_rdata;
   logic [7:0] level = 8'h00; // Source levels for the model
   logic pwm, cmp, spi, uart, refc, mpin, pin1, pin2;
   logic out_pin, slew, pwm_b, cmp_b, spi_b, uart_b, ref_b;
   int failures = 0;
   int checks = 0;
   // Tables: modulator codes, their level bit and pin blocked
   sgm_code_t mcode [5] = '{4'h1, 4'h2, 4'h6, 4'h8, 4'hA};
   int mbit [5] = '{5, 0, 1, 2, 3};
   logic [3:0] mblk [5] = '{4'h0, 4'h8, 4'h4, 4'h2, 4'h1};
   // Carrier level bit per code 0..5; negative means nothing
   int cbit [6] = '{-1, 6, 7, 4, 0, -1};

   initial
   begin
      forever #5 clock = ~clock;
   end

   sgm_far_model sgm_far_model_inst (.clock(clock), .level(level),
      .pwm_out(pwm), .comparator_out(cmp), .spi_data_out(spi),
      .uart_tx_out(uart), .reference_clock_output(refc),
      .modulation_input_pin(mpin), .carrier_input_pin_one(pin1),
      .carrier_input_pin_two(pin2));

   sgm_top sgm_top_inst (.clock(clock), .rst_n(rst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pwm_out(pwm),
      .comparator_out(cmp), .spi_data_out(spi), .uart_tx_out(uart),
      .reference_clock_output(refc), .modulation_input_pin(mpin),
      .carrier_input_pin_one(pin1), .carrier_input_pin_two(pin2),
      .modulated_out_pin(out_pin), .output_slew_limit(slew),
      .pwm_pin_block(pwm_b), .comparator_pin_block(cmp_b),
      .spi_pin_block(spi_b), .uart_pin_block(uart_b),
      .refclk_pin_block(ref_b));

   // Compare and count; a mismatch is reported at once
   task automatic check(input string what, input sgm_byte_t seen,
      input sgm_byte_t exp);
      checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // One-cycle write; the gap after it keeps strobes apart
   task automatic wr(input sgm_addr_t a, input sgm_byte_t d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input string what, input sgm_addr_t a,
      input sgm_byte_t exp);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      check(what, reg_rdata, exp);
   endtask

   // Sources change just after an edge
   task automatic drive(input logic [7:0] v);
      @(posedge clock);
      level <= v;
   endtask

   // Six cycles cover the pin synchroniser and output register
   task automatic pin_chk(input string what, input logic exp);
      repeat (6) @(posedge clock);
      #1;
      check(what, {7'h00, out_pin}, {7'h00, exp});
   endtask

   // Walk one carrier register through codes 0..5
   task automatic car_scan(input sgm_addr_t a, input bit low);
      int b;
      for (int k = 0; k < 6; k++)
      begin
         b = (low && k == 2) ? -1 : cbit[k];
         wr(a, {4'h0, 4'(k)});
         if (b < 0)
         begin
            drive(8'hFF);
            pin_chk("carrier none", 1'b0);
         end
         else
         begin
            drive(8'h01 << b);
            pin_chk("carrier on", 1'b1);
            drive(~(8'h01 << b));
            pin_chk("carrier off", 1'b0);
         end
      end
   endtask

   task automatic done(input string name);
      $display("test %s done", name);
   endtask

   // The one place where the run ends
   task automatic finish_test;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Watchdog; the whole run needs well under 10000 cycles
   initial
   begin
      #200000;
      failures++;
      $display("watchdog expired");
      finish_test();
   end

   initial
   begin
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      #1;
      check("slew at reset", {7'h00, slew}, 8'h01);
      check("pin at reset", {7'h00, out_pin}, 8'h00);
      rd_chk("control reset", `SGM_OFS_CONTROL, `SGM_CTL_RESET);
      // Unimplemented and read-only bits ignore writes
      wr(`SGM_OFS_CONTROL, 8'h0E);
      rd_chk("control bits", `SGM_OFS_CONTROL, 8'h00);
      check("slew cleared", {7'h00, slew}, 8'h00);
      wr(`SGM_OFS_SOURCE, 8'hFF);
      rd_chk("source bits", `SGM_OFS_SOURCE, 8'h8F);
      wr(`SGM_OFS_CARRIER_HIGH_SIGNAL, 8'hFF);
      rd_chk("carrier_high_signal bits", `SGM_OFS_CARRIER_HIGH_SIGNAL, 8'hEF);
      wr(`SGM_OFS_CARRIER_LOW_SIGNAL, 8'hFF);
      rd_chk("carrier_low_signal bits", `SGM_OFS_CARRIER_LOW_SIGNAL, 8'hEF);
      done("registers");
      // Firmware configures both carriers before enabling; the source follows
      wr(`SGM_OFS_CARRIER_HIGH_SIGNAL, 8'h03);
      wr(`SGM_OFS_CARRIER_LOW_SIGNAL, 8'h00);
      wr(`SGM_OFS_CONTROL, 8'hC0);
      for (int k = 0; k < 5; k++)
      begin
         wr(`SGM_OFS_SOURCE, {4'h0, mcode[k]});
         drive(8'h10 | (8'h01 << mbit[k]));
         pin_chk("mod high", 1'b1);
         drive(8'hFF & ~(8'h01 << mbit[k]));
         pin_chk("mod low", 1'b0);
         wr(`SGM_OFS_SOURCE, {4'h8, mcode[k]});
         // Pin blocks are registered: look one edge after the write
         @(posedge clock);
         #1;
         check("mod block", {4'h0, pwm_b, cmp_b, spi_b, uart_b},
            {4'h0, mblk[k]});
      end
      wr(`SGM_OFS_SOURCE, 8'h03);
      drive(8'hFF);
      pin_chk("mod reserved", 1'b0);
      wr(`SGM_OFS_SOURCE, 8'h00);
      wr(`SGM_OFS_CONTROL, 8'hC1);
      pin_chk("soft bit one", 1'b1);
      wr(`SGM_OFS_CARRIER_HIGH_SIGNAL, 8'h83);
      @(posedge clock);
      #1;
      check("ref block", {7'h00, ref_b}, 8'h01);
      pin_chk("carrier kept", 1'b1);
      wr(`SGM_OFS_CARRIER_LOW_SIGNAL, 8'h84);
      @(posedge clock);
      #1;
      check("pwm block", {7'h00, pwm_b}, 8'h01);
      wr(`SGM_OFS_CONTROL, 8'hC0);
      // Low carrier (pwm) low, high carrier high: shows which is used
      drive(8'hFE);
      pin_chk("soft bit zero", 1'b0);
      done("sources");
      wr(`SGM_OFS_CONTROL, 8'hC1);
      car_scan(`SGM_OFS_CARRIER_HIGH_SIGNAL, 1'b0);
      wr(`SGM_OFS_CONTROL, 8'hC0);
      car_scan(`SGM_OFS_CARRIER_LOW_SIGNAL, 1'b1);
      // Inverted ground low carrier gives a steady one
      wr(`SGM_OFS_CARRIER_LOW_SIGNAL, 8'h40);
      drive(8'h00);
      pin_chk("low invert", 1'b1);
      wr(`SGM_OFS_CONTROL, 8'hD0);
      pin_chk("out invert", 1'b0);
      rd_chk("monitor inv", `SGM_OFS_CONTROL, 8'hD0);
      wr(`SGM_OFS_CONTROL, 8'h80);
      pin_chk("pin disabled", 1'b0);
      rd_chk("monitor on", `SGM_OFS_CONTROL, 8'h88);
      wr(`SGM_OFS_CONTROL, 8'h40);
      pin_chk("module off", 1'b0);
      rd_chk("carrier_low_signal kept", `SGM_OFS_CARRIER_LOW_SIGNAL, 8'h40);
      wr(`SGM_OFS_CONTROL, 8'hC0);
      pin_chk("module back", 1'b1);
      done("carriers");
      // High carrier sync holds the switch until the carrier falls
      wr(`SGM_OFS_CARRIER_LOW_SIGNAL, 8'h00);
      wr(`SGM_OFS_CARRIER_HIGH_SIGNAL, 8'h23);
      drive(8'h10);
      wr(`SGM_OFS_CONTROL, 8'hC1);
      pin_chk("sync start", 1'b1);
      wr(`SGM_OFS_CONTROL, 8'hC0);
      pin_chk("sync held", 1'b1);
      drive(8'h00);
      pin_chk("sync fall", 1'b0);
      drive(8'h10);
      pin_chk("sync switched", 1'b0);
      // Low sync acts only when leaving the low carrier
      wr(`SGM_OFS_CARRIER_HIGH_SIGNAL, 8'h03);
      wr(`SGM_OFS_CONTROL, 8'hC1);
      pin_chk("nosync high", 1'b1);
      wr(`SGM_OFS_CARRIER_LOW_SIGNAL, 8'h20);
      wr(`SGM_OFS_CONTROL, 8'hC0);
      pin_chk("nosync low", 1'b0);
      wr(`SGM_OFS_CONTROL, 8'hC1);
      pin_chk("low sync held", 1'b0);
      done("sync");
      finish_test();
   end
endmodule // sgm_top_test
`default_nettype wire
